// *** rom_bank_model.sv ***
// Behavioural ROM banks on the GP and SDRAM data lines
`timescale 1ns/10ps
module rom_bank_model (
  input  wire        clk,
  input  wire [2:0]  sel_n,
  input  wire [2:0]  on_sdram,
  input  wire        rd_n,
  input  wire [25:0] addr,
  input  wire        gp_oe,
  input  wire [15:0] gp_out,
  input  wire        sd_oe,
  input  wire [31:0] sd_out,
  output wire [15:0] gp_in,
  output wire [31:0] sd_in
);
  reg  [31:0] noise = 32'h00000000;
  wire [31:0] pat   = {addr[15:0], ~addr[15:0]};
  // Released lines wander every cycle so stale data never reads as valid
  always @(posedge clk) noise <= noise + 32'h9E3779B9;
  assign sd_in = sd_oe ? sd_out : (!rd_n && |(~sel_n & on_sdram)) ? pat : noise;
  assign gp_in = gp_oe ? gp_out : (!rd_n && |(~sel_n & ~on_sdram)) ? pat[15:0] : noise[15:0];
endmodule // rom_bank_model

// *** rom_chip_select_controller.v ***
// ROM chip select controller: decode, straps, control registers, shared pins, strobes
`timescale 1ns/10ps
`include "rom_cs_defines.vh"
module rom_chip_select_controller (
  input  wire        CLK_SYS,
  input  wire        RST,
  // Straps and power good, asynchronous pins
  input  wire        PWR_GOOD,
  input  wire        BOOT_BUS_STRAP,
  input  wire [1:0]  BOOT_WIDTH_STRAPS,
  // Configuration register port
  input  wire        CFG_WR,
  input  wire        CFG_RD,
  input  wire [11:0] CFG_ADDR,
  input  wire [15:0] CFG_WDATA,
  output reg  [15:0] CFG_RDATA,
  // Processor access request, already decoded to a select
  input  wire        ACC_REQ,
  input  wire        ACC_WRITE,
  input  wire        ACC_EXEC,
  input  wire        ACC_CACHE,
  input  wire        ACC_IN_PAGE,
  input  wire [1:0]  ACC_SEL,
  input  wire [25:0] ACC_ADDR,
  input  wire [31:0] ACC_WDATA,
  output reg  [31:0] ACC_RDATA,
  output wire        ACC_READY,
  output reg         ACC_FAULT,
  output wire        ACC_CACHEABLE,
  // General-purpose chip selects from the GP bus controller
  input  wire        FIRST_GP_SELECT_IN,
  input  wire        SECOND_GP_SELECT_IN,
  // Pins
  output reg         BOOT_ROM_SELECT_N,
  output reg         SHARED_PIN1_N,
  output reg         SHARED_PIN2_N,
  output reg  [25:0] GP_ADDR,
  input  wire [15:0] GP_DATA_IN,
  input  wire [31:0] SDRAM_DATA_IN,
  output reg  [15:0] GP_DATA_OUT,
  output reg         GP_DATA_OE,
  output reg  [31:0] SDRAM_DATA_OUT,
  output reg         SDRAM_DATA_OE,
  output reg         ROM_BUFFER_OUTPUT_ENABLE_N,
  output reg         ROM_READ_STROBE_N,
  output reg         ROM_WRITE_STROBE_N,
  output wire        SDRAM_BUFFER_BYPASS
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_WAIT  = 2'h1;
  localparam ST_DONE  = 2'h2;

  function [15:0] ctl_write;
    input [15:0] d;
    reg   [15:0] v;
    begin
      v = d & `CTL_MASK;
      // A 32-bit bank on the GP data bus is illegal; fall back to 16 bits
      if (!v[`CTL_BUS_BIT] && v[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB] != `WIDTH_8)
        v[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB] = `WIDTH_16;
      ctl_write = v;
    end
  endfunction

  // Power good and straps pass two flops before use
  reg       pg_s1_r, pg_s2_r, pg_s3_r;
  reg [2:0] strap_s1_r, strap_s2_r;
  reg [15:0] boot_ctl_r, second_ctl_r, third_ctl_r, pin_func_r, attr_r;
  reg [15:0] boot_ctl_nxt;
  reg [1:0] state_r;
  reg [15:0] cur_ctl_r;
  reg       is_write_r;
  reg       read_ack_r;

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pg_s1_r    <= 1'b0;
      pg_s2_r    <= 1'b0;
      pg_s3_r    <= 1'b0;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end else begin
      pg_s1_r    <= PWR_GOOD;
      pg_s2_r    <= pg_s1_r;
      pg_s3_r    <= pg_s2_r;
      strap_s1_r <= {BOOT_BUS_STRAP, BOOT_WIDTH_STRAPS};
      strap_s2_r <= strap_s1_r;
    end
  end

  wire pg_rise = pg_s2_r && !pg_s3_r;

  always @* begin
    boot_ctl_nxt = boot_ctl_r;
    if (CFG_WR && CFG_ADDR == `OFS_BOOT_CTL)
      boot_ctl_nxt = (CFG_WDATA & `CTL_MASK);
    if (pg_rise) begin
      boot_ctl_nxt[`CTL_BUS_BIT] = strap_s2_r[2];
      boot_ctl_nxt[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB] = strap_s2_r[1:0];
    end else if (CFG_WR && CFG_ADDR == `OFS_BOOT_CTL) begin
      // Strap-derived fields stay as latched
      boot_ctl_nxt[`CTL_BUS_BIT] = boot_ctl_r[`CTL_BUS_BIT];
      boot_ctl_nxt[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB] = boot_ctl_r[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB];
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      boot_ctl_r   <= `CTL_RESET;
      second_ctl_r <= `SECOND_CTL_RESET;
      third_ctl_r  <= `SECOND_CTL_RESET;
      pin_func_r   <= `PIN_FUNC_RESET;
      attr_r       <= `ATTR_RESET;
    end else begin
      boot_ctl_r <= boot_ctl_nxt;
      if (CFG_WR) begin
        case (CFG_ADDR)
          `OFS_SECOND_CTL:  second_ctl_r <= ctl_write(CFG_WDATA);
          `OFS_THIRD_CTL:   third_ctl_r  <= ctl_write(CFG_WDATA);
          `OFS_PIN_FUNC:    pin_func_r   <= CFG_WDATA & `PIN_FUNC_MASK;
          `OFS_REGION_ATTR: attr_r       <= CFG_WDATA;
          default: ;
        endcase
      end
    end
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CFG_RDATA <= 16'h0000;
    end else if (CFG_RD) begin
      case (CFG_ADDR)
        `OFS_BOOT_CTL:    CFG_RDATA <= boot_ctl_r;
        `OFS_SECOND_CTL:  CFG_RDATA <= second_ctl_r;
        `OFS_THIRD_CTL:   CFG_RDATA <= third_ctl_r;
        `OFS_PIN_FUNC:    CFG_RDATA <= pin_func_r;
        `OFS_REGION_ATTR: CFG_RDATA <= attr_r;
        default:          CFG_RDATA <= 16'h0000;
      endcase
    end
  end

  // Select 1 and 2 are only usable when their pin is given to the ROM function
  wire rom1_pin = !pin_func_r[`PIN_FIRST_BIT];
  wire rom2_pin = !pin_func_r[`PIN_SECOND_BIT];
  wire sel_ok   = (ACC_SEL == 2'h0) || (ACC_SEL == 2'h1 && rom1_pin) || (ACC_SEL == 2'h2 && rom2_pin);
  wire [15:0] sel_ctl = (ACC_SEL == 2'h1) ? second_ctl_r : (ACC_SEL == 2'h2) ? third_ctl_r : boot_ctl_r;
  wire [7:0]  sel_attr = (ACC_SEL == 2'h1) ? {5'h00, attr_r[6:4]} :
                         (ACC_SEL == 2'h2) ? {5'h00, attr_r[10:8]} : {5'h00, attr_r[2:0]};
  wire attr_bad = (ACC_WRITE && sel_attr[`ATTR_WP_BIT]) || (ACC_EXEC && !sel_attr[`ATTR_EXEC_BIT]);
  assign ACC_CACHEABLE = ACC_CACHE && sel_attr[`ATTR_CACHE_BIT];

  // Page mode uses the short delay only for in-page follow-on accesses
  wire use_sub = sel_ctl[`CTL_MODE_BIT] && ACC_IN_PAGE;
  wire [2:0] waits = use_sub ? {1'b0, sel_ctl[`CTL_SUB_MSB:`CTL_SUB_LSB]}
                             : sel_ctl[`CTL_FIRST_MSB:`CTL_FIRST_LSB];
  wire start = (state_r == ST_IDLE) && ACC_REQ && sel_ok && !attr_bad;
  wire timer_done;

  rom_wait_timer u_timer (
    .clk   (CLK_SYS),
    .rst   (RST),
    .start (start),
    .waits (waits),
    .done  (timer_done)
  );

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r    <= ST_IDLE;
      cur_ctl_r  <= 16'h0000;
      is_write_r <= 1'b0;
      read_ack_r <= 1'b0;
      ACC_FAULT  <= 1'b0;
      ACC_RDATA  <= 32'h00000000;
      GP_ADDR    <= 26'h0000000;
      BOOT_ROM_SELECT_N          <= 1'b1;
      ROM_BUFFER_OUTPUT_ENABLE_N <= 1'b1;
      ROM_READ_STROBE_N          <= 1'b1;
      ROM_WRITE_STROBE_N         <= 1'b1;
      GP_DATA_OUT    <= 16'h0000;
      GP_DATA_OE     <= 1'b0;
      SDRAM_DATA_OUT <= 32'h00000000;
      SDRAM_DATA_OE  <= 1'b0;
    end else begin
      ACC_FAULT  <= 1'b0;
      read_ack_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (ACC_REQ && (!sel_ok || attr_bad)) begin
            ACC_FAULT <= 1'b1;
          end else if (start) begin
            state_r    <= ST_WAIT;
            cur_ctl_r  <= sel_ctl;
            is_write_r <= ACC_WRITE;
            GP_ADDR    <= ACC_ADDR;
            BOOT_ROM_SELECT_N          <= (ACC_SEL != 2'h0);
            ROM_BUFFER_OUTPUT_ENABLE_N <= 1'b0;
            ROM_READ_STROBE_N          <= ACC_WRITE;
            ROM_WRITE_STROBE_N         <= !ACC_WRITE;
            if (ACC_WRITE) begin
              GP_DATA_OUT    <= ACC_WDATA[15:0];
              GP_DATA_OE     <= !sel_ctl[`CTL_BUS_BIT];
              SDRAM_DATA_OUT <= ACC_WDATA;
              SDRAM_DATA_OE  <= sel_ctl[`CTL_BUS_BIT];
            end
          end
        end
        ST_WAIT: begin
          if (timer_done) begin
            state_r <= ST_DONE;
            if (!is_write_r) begin
              read_ack_r <= 1'b1;
              // Data comes straight off the pins, never through SDRAM buffers
              if (cur_ctl_r[`CTL_BUS_BIT]) begin
                case (cur_ctl_r[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB])
                  `WIDTH_8:  ACC_RDATA <= {24'h000000, SDRAM_DATA_IN[7:0]};
                  `WIDTH_16: ACC_RDATA <= {16'h0000, SDRAM_DATA_IN[15:0]};
                  default:   ACC_RDATA <= SDRAM_DATA_IN;
                endcase
              end else begin
                case (cur_ctl_r[`CTL_WIDTH_MSB:`CTL_WIDTH_LSB])
                  `WIDTH_8: ACC_RDATA <= {24'h000000, GP_DATA_IN[7:0]};
                  default:  ACC_RDATA <= {16'h0000, GP_DATA_IN};
                endcase
              end
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
          BOOT_ROM_SELECT_N          <= 1'b1;
          ROM_BUFFER_OUTPUT_ENABLE_N <= 1'b1;
          ROM_READ_STROBE_N          <= 1'b1;
          ROM_WRITE_STROBE_N         <= 1'b1;
          GP_DATA_OE    <= 1'b0;
          SDRAM_DATA_OE <= 1'b0;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  wire active = (state_r != ST_IDLE);
  // Writes finish when the strobe ends; reads when data is captured
  assign ACC_READY = read_ack_r || (state_r == ST_DONE && is_write_r);
  // Held while any ROM cycle runs so the SDRAM side keeps its buffers out of it
  assign SDRAM_BUFFER_BYPASS = active;

  // Shared pins carry only the chosen function
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SHARED_PIN1_N <= 1'b1;
      SHARED_PIN2_N <= 1'b1;
    end else begin
      SHARED_PIN1_N <= rom1_pin ? !(start && ACC_SEL == 2'h1) && !(active && !SHARED_PIN1_N && state_r != ST_DONE)
                                : !FIRST_GP_SELECT_IN;
      SHARED_PIN2_N <= rom2_pin ? !(start && ACC_SEL == 2'h2) && !(active && !SHARED_PIN2_N && state_r != ST_DONE)
                                : !SECOND_GP_SELECT_IN;
    end
  end
endmodule // rom_chip_select_controller

// *** rom_cs_defines.vh ***
// Offsets, field positions, masks, reset values and codes for the ROM chip select controller
`ifndef ROM_CS_DEFINES_VH
`define ROM_CS_DEFINES_VH
`define OFS_BOOT_CTL        12'h050
`define OFS_SECOND_CTL      12'h054
`define OFS_THIRD_CTL       12'h056
`define OFS_PIN_FUNC        12'hC24
`define OFS_REGION_ATTR     12'h0A0
// Control register fields
`define CTL_FIRST_LSB       0
`define CTL_FIRST_MSB       2
`define CTL_SUB_LSB         4
`define CTL_SUB_MSB         5
`define CTL_MODE_BIT        8
`define CTL_WIDTH_LSB       9
`define CTL_WIDTH_MSB       10
`define CTL_BUS_BIT         12
`define CTL_MASK            16'h1777
`define CTL_RESET           16'h0007
`define SECOND_CTL_RESET    16'h0007
`define PIN_FUNC_MASK       16'h0006
`define PIN_FUNC_RESET      16'h0000
`define PIN_FIRST_BIT       1
`define PIN_SECOND_BIT      2
// Width codes
`define WIDTH_8             2'h0
`define WIDTH_16            2'h1
`define WIDTH_32            2'h2
// Region attribute fields, one nibble per select
`define ATTR_EXEC_BIT       0
`define ATTR_CACHE_BIT      1
`define ATTR_WP_BIT         2
`define ATTR_RESET          16'h0000
// Each select decodes up to 64 Mbytes
`define REGION_ADDR_BITS    26
`endif

// *** rom_cs_properties.sv ***
// Concurrent checks on the ROM chip select controller pins
`timescale 1ns/10ps
module rom_cs_properties (
  input wire        CLK_SYS,
  input wire        RST,
  input wire        ACC_REQ,
  input wire        ACC_WRITE,
  input wire [1:0]  ACC_SEL,
  input wire [25:0] ACC_ADDR,
  input wire        ACC_READY,
  input wire        ACC_FAULT,
  input wire        ACC_CACHE,
  input wire        ACC_CACHEABLE,
  input wire        BOOT_ROM_SELECT_N,
  input wire        SHARED_PIN1_N,
  input wire        SHARED_PIN2_N,
  input wire [25:0] GP_ADDR,
  input wire        GP_DATA_OE,
  input wire        SDRAM_DATA_OE,
  input wire        ROM_BUFFER_OUTPUT_ENABLE_N,
  input wire        ROM_READ_STROBE_N,
  input wire        SDRAM_BUFFER_BYPASS
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_addr_on_gp: assert property (!ROM_READ_STROBE_N && ACC_REQ |-> GP_ADDR == ACC_ADDR)
    else $error("address not on GP lines");
  chk_buffer_during_read: assert property (!ROM_READ_STROBE_N |-> !ROM_BUFFER_OUTPUT_ENABLE_N)
    else $error("buffer enable off in ROM read");
  chk_strobe_needs_select: assert property (!ROM_READ_STROBE_N |->
    (!BOOT_ROM_SELECT_N || !SHARED_PIN1_N || !SHARED_PIN2_N))
    else $error("read strobe without ROM select");
  chk_no_strobe_write: assert property (ACC_REQ && ACC_WRITE |-> ROM_READ_STROBE_N)
    else $error("read strobe in write");
  chk_sdram_bypass: assert property ($fell(ROM_READ_STROBE_N) |-> SDRAM_BUFFER_BYPASS)
    else $error("SDRAM buffers not bypassed");
  chk_ready_bound: assert property ($fell(ROM_READ_STROBE_N) |-> ##[1:9] ACC_READY)
    else $error("read not answered in delay bound");
  chk_bad_select: assert property ($rose(ACC_REQ) && ACC_SEL == 2'h3 |=> ACC_FAULT)
    else $error("fourth select not refused");
  chk_cache_gate: assert property (ACC_CACHEABLE |-> ACC_CACHE)
    else $error("cacheable without request");
  chk_one_bus: assert property ((GP_DATA_OE || SDRAM_DATA_OE) |->
    !(GP_DATA_OE && SDRAM_DATA_OE) && ROM_READ_STROBE_N)
    else $error("two data buses driven");
endmodule // rom_cs_properties
bind rom_chip_select_controller rom_cs_properties i_rom_cs_properties (.CLK_SYS(CLK_SYS), .RST(RST),
  .ACC_REQ(ACC_REQ), .ACC_WRITE(ACC_WRITE), .ACC_SEL(ACC_SEL), .ACC_ADDR(ACC_ADDR), .ACC_READY(ACC_READY),
  .ACC_FAULT(ACC_FAULT), .ACC_CACHE(ACC_CACHE), .ACC_CACHEABLE(ACC_CACHEABLE),
  .BOOT_ROM_SELECT_N(BOOT_ROM_SELECT_N), .SHARED_PIN1_N(SHARED_PIN1_N), .SHARED_PIN2_N(SHARED_PIN2_N),
  .GP_ADDR(GP_ADDR), .GP_DATA_OE(GP_DATA_OE), .SDRAM_DATA_OE(SDRAM_DATA_OE),
  .ROM_BUFFER_OUTPUT_ENABLE_N(ROM_BUFFER_OUTPUT_ENABLE_N), .ROM_READ_STROBE_N(ROM_READ_STROBE_N),
  .SDRAM_BUFFER_BYPASS(SDRAM_BUFFER_BYPASS));

// *** rom_wait_timer.v ***
// Wait state counter for one ROM access
`timescale 1ns/10ps
module rom_wait_timer (
  input  wire       clk,
  input  wire       rst,
  input  wire       start,
  input  wire [2:0] waits,
  output reg        done
);
  reg [2:0] cnt_r;
  reg       busy_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        if (waits == 3'h0) begin
          done <= 1'b1;
        end else begin
          cnt_r  <= waits;
          busy_r <= 1'b1;
        end
      end else if (busy_r) begin
        if (cnt_r == 3'h1) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end
endmodule // rom_wait_timer

// *** testbench.sv ***
// Self-checking bench for the ROM chip select controller
`timescale 1ns/10ps
`include "rom_cs_defines.vh"
module testbench;
  reg clk = 0, rst = 1, pg = 0, bstrap = 1, cwr = 0, crd = 0, req = 0, wr = 0, ex = 0, ca = 0, inpg = 0;
  reg gp1 = 0, gp2 = 0, cpend = 0;
  reg [1:0] wstrap = 2'h2, sel = 2'h0;
  reg [2:0] bus = 3'h5;
  reg [11:0] cad = 12'h000;
  reg [15:0] cwd = 16'h0000, d;
  reg [25:0] ad = 26'h0000000;
  reg [31:0] wd = 32'h00000000, rnd, q[$];
  wire [15:0] crdat, gpi, gpo;
  wire [31:0] ard, sdi, sdo;
  wire [25:0] gpa;
  wire rdy, flt, cch, bcs, p1, p2, gpoe, sdoe, boe, rds, wrs, byp;
  integer err_count = 0, total_checks = 0, seed = 39216, i;
  rom_chip_select_controller i_rom_chip_select_controller (.CLK_SYS(clk), .RST(rst), .PWR_GOOD(pg),
    .BOOT_BUS_STRAP(bstrap), .BOOT_WIDTH_STRAPS(wstrap), .CFG_WR(cwr), .CFG_RD(crd), .CFG_ADDR(cad),
    .CFG_WDATA(cwd), .CFG_RDATA(crdat), .ACC_REQ(req), .ACC_WRITE(wr), .ACC_EXEC(ex), .ACC_CACHE(ca),
    .ACC_IN_PAGE(inpg), .ACC_SEL(sel), .ACC_ADDR(ad), .ACC_WDATA(wd), .ACC_RDATA(ard), .ACC_READY(rdy),
    .ACC_FAULT(flt), .ACC_CACHEABLE(cch), .FIRST_GP_SELECT_IN(gp1), .SECOND_GP_SELECT_IN(gp2),
    .BOOT_ROM_SELECT_N(bcs), .SHARED_PIN1_N(p1), .SHARED_PIN2_N(p2), .GP_ADDR(gpa), .GP_DATA_IN(gpi),
    .SDRAM_DATA_IN(sdi), .GP_DATA_OUT(gpo), .GP_DATA_OE(gpoe), .SDRAM_DATA_OUT(sdo), .SDRAM_DATA_OE(sdoe),
    .ROM_BUFFER_OUTPUT_ENABLE_N(boe), .ROM_READ_STROBE_N(rds), .ROM_WRITE_STROBE_N(wrs),
    .SDRAM_BUFFER_BYPASS(byp));
  rom_bank_model i_rom_bank_model (.clk(clk), .sel_n({p2, p1, bcs}), .on_sdram(bus), .rd_n(rds), .addr(gpa),
    .gp_oe(gpoe), .gp_out(gpo), .sd_oe(sdoe), .sd_out(sdo), .gp_in(gpi), .sd_in(sdi));
  initial begin
    forever #20 clk = ~clk;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task cfg_wr(input [11:0] a, input [15:0] v);
    begin
      @(negedge clk);
      cad = a;
      cwd = v;
      cwr = 1;
      @(negedge clk);
      cwr = 0;
    end
  endtask
  task cfg_rd(input [11:0] a, input [15:0] v);
    begin
      @(negedge clk);
      cad = a;
      crd = 1;
      q.push_back({16'h0000, v});
      @(negedge clk);
      crd = 0;
    end
  endtask
  // Address is random; expected data is the bank pattern cut to the bank width
  task acc(input [1:0] s, input w, input [1:0] wc, input f);
    integer n;
    begin
      @(negedge clk);
      rnd = $random(seed);
      sel = s;
      wr = w;
      ad = rnd[25:0];
      wd = ~rnd;
      req = 1;
      if (!w && !f) q.push_back(wc == 2'h2 ? {ad[15:0], ~ad[15:0]} : wc == 2'h1 ? {16'h0000, ~ad[15:0]} :
        {24'h000000, ~ad[7:0]});
      n = 0;
      while (rdy !== 1'b1 && flt !== 1'b1 && n < 40) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n >= 40) begin
        err_count = err_count + 1;
        report_and_stop;
      end
      check({31'h0, flt}, {31'h0, f});
      @(negedge clk);
      req = 0;
    end
  endtask
  always @(posedge clk) begin
    if (cpend || (rdy === 1'b1 && !wr)) begin
      if (q.size() > 0) check(cpend ? {16'h0000, crdat} : ard, q.pop_front());
      else check(32'h1, 32'h0);
    end
    cpend <= crd;
  end
  // Cache and page qualifiers wander freely; page shifts the wait count, cache only the cacheable output
  always @(negedge clk) begin
    ca <= $random(seed);
    inpg <= $random(seed);
  end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    cfg_rd(`OFS_SECOND_CTL, `SECOND_CTL_RESET);
    cfg_rd(`OFS_PIN_FUNC, `PIN_FUNC_RESET);
    cfg_rd(12'h100, 16'h0000);
    pg = 1;
    repeat (6) @(negedge clk);
    cfg_rd(`OFS_BOOT_CTL, 16'h1407);
    cfg_wr(`OFS_BOOT_CTL, 16'h0000);
    cfg_rd(`OFS_BOOT_CTL, 16'h1400);
    cfg_wr(`OFS_SECOND_CTL, 16'h0401);
    cfg_rd(`OFS_SECOND_CTL, 16'h0201);
    rnd = $random(seed);
    d = 16'h1100 | (rnd[15:0] & 16'h0077);
    cfg_wr(`OFS_THIRD_CTL, d);
    cfg_rd(`OFS_THIRD_CTL, d);
    $display("done: registers and straps");
    for (i = 0; i < 4; i = i + 1) begin
      acc(2'h0, 0, 2'h2, 0);
      acc(2'h1, 0, 2'h1, 0);
      acc(2'h2, 0, 2'h0, 0);
      acc(2'h1, 1, 2'h1, 0);
    end
    acc(2'h3, 0, 2'h0, 1);
    $display("done: accesses");
    cfg_wr(`OFS_REGION_ATTR, 16'h0004);
    acc(2'h0, 1, 2'h2, 1);
    ex = 1;
    acc(2'h1, 0, 2'h1, 1);
    ex = 0;
    // Boot region cacheable: the output must follow the wandering cache request
    cfg_wr(`OFS_REGION_ATTR, 16'h0002);
    sel = 2'h0;
    repeat (2) @(negedge clk);
    check({31'h0, cch}, {31'h0, ca});
    $display("done: region attributes");
    cfg_wr(`OFS_PIN_FUNC, 16'hFFFB);
    cfg_rd(`OFS_PIN_FUNC, 16'h0002);
    gp1 = 1;
    gp2 = 1;
    repeat (2) @(negedge clk);
    check({31'h0, p1}, 32'h0);
    check({31'h0, p2}, 32'h1);
    acc(2'h1, 0, 2'h1, 1);
    acc(2'h2, 0, 2'h0, 0);
    repeat (4) @(negedge clk);
    check(q.size(), 0);
    $display("done: shared pins");
    report_and_stop;
  end
endmodule // testbench
